//--- hdl/receiver_autopoll_bitcheck_control.sv
// Control word register, decoded receiver settings and the auto-poll/bitcheck machine.
// Assumes rx_data_in is the sliced data and the select pins read high when floating.
`timescale 1ns/1ns
module receiver_autopoll_bitcheck_control #(
    parameter int MS_CYCLES = rx_ctrl_pkg::MS_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [rx_ctrl_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [31:0] rdata,
    input wire logic bw_select_pin_lo,
    input wire logic bw_select_pin_hi,
    input wire logic rx_data_in,
    output logic data_out,
    output logic rx_awake,
    output logic [13:0] filter_bw_hz,
    output logic fast_bw,
    output logic [6:0] slice_percent,
    output logic [2:0] desense_code,
    output logic squelch_en,
    output logic [7:0] rssi_offset_mv
);
    typedef enum logic [1:0] {awake_s, sleep_s, check_s, wake_s} poll_state_t;

    // ---------------------------------------------------------------
    // Pins and time base
    // ---------------------------------------------------------------
    logic [2:0] sync_bits;
    logic pin_lo_s;
    logic pin_hi_s;
    logic data_s;
    logic ms_tick;

    bit_sync #(
        .W(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({rx_data_in, bw_select_pin_hi, bw_select_pin_lo}),
        .sync_out(sync_bits)
    );

    assign pin_lo_s = sync_bits[0];
    assign pin_hi_s = sync_bits[1];
    assign data_s = sync_bits[2];

    // Stands in for the sleep oscillator; never gated by the poll state
    pulse_divider #(
        .DIV(MS_CYCLES)
    ) u_ms_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .tick(ms_tick)
    );

    // ---------------------------------------------------------------
    // Control word and register port
    // ---------------------------------------------------------------
    rx_ctrl_pkg::ctrl_word_t ctrl_reg;
    rx_ctrl_pkg::ctrl_word_t ctrl_next;
    logic [31:0] rdata_next;
    logic [31:0] status_word;
    logic [1:0] eff_bw;
    logic [13:0] filter_bw_next;
    logic [6:0] slice_next;
    logic [7:0] rssi_next;

    // Open pins read high, so the word alone decides unless a pin is tied low
    assign eff_bw = ctrl_reg.bw_code & {pin_hi_s, pin_lo_s};

    always_comb begin
        ctrl_next = ctrl_reg;
        rdata_next = 32'h0000_0000;
        if (wr_strobe && addr == rx_ctrl_pkg::CTRL_ADDR) begin
            ctrl_next = rx_ctrl_pkg::ctrl_word_t'(wdata[rx_ctrl_pkg::CTRL_W-1:0]);
        end
        if (rd_strobe) begin
            if (addr == rx_ctrl_pkg::STATUS_ADDR) begin
                rdata_next = status_word;
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
        filter_bw_next = rx_ctrl_pkg::bw_hz_of(eff_bw);
        slice_next = rx_ctrl_pkg::SLICE_PCT[ctrl_reg.slice_code];
        rssi_next = ctrl_reg.rssi_offset_bit ? rx_ctrl_pkg::RSSI_OFFSET_MV : 8'h00;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= rx_ctrl_pkg::ctrl_word_t'(rx_ctrl_pkg::CTRL_RESET);
            rdata <= 32'h0000_0000;
            filter_bw_hz <= 14'h0000;
            fast_bw <= 1'b0;
            slice_percent <= 7'h00;
            desense_code <= 3'h0;
            squelch_en <= 1'b0;
            rssi_offset_mv <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata <= rdata_next;
            filter_bw_hz <= filter_bw_next;
            fast_bw <= ctrl_reg.fast_bw_bit;
            slice_percent <= slice_next;
            desense_code <= ctrl_reg.desense_code;
            squelch_en <= ctrl_reg.squelch_bit;
            rssi_offset_mv <= rssi_next;
        end
    end

    // ---------------------------------------------------------------
    // Auto-poll and bitcheck machine
    // ---------------------------------------------------------------
    poll_state_t state_reg;
    poll_state_t state_next;
    logic poll_d_reg;
    logic data_d_reg;
    logic seen_reg;
    logic seen_next;
    logic [15:0] ival_reg;
    logic [15:0] ival_next;
    logic [10:0] ms_reg;
    logic [10:0] ms_next;
    logic [4:0] good_reg;
    logic [4:0] good_next;
    logic [1:0] bad_reg;
    logic [1:0] bad_next;
    logic data_out_next;
    logic poll_rise;
    logic edge_seen;
    logic good_pulse;
    logic bad_pulse;
    logic [10:0] sleep_ms;
    logic [10:0] wd_ms;
    logic [15:0] win_cyc;
    logic [4:0] pulse_target;

    assign poll_rise = ctrl_reg.autopoll_enable_bit && !poll_d_reg;
    assign edge_seen = data_s != data_d_reg;
    assign sleep_ms = rx_ctrl_pkg::sleep_ms_of(ctrl_reg.sleep_code);
    assign wd_ms = rx_ctrl_pkg::wd_ms_of(eff_bw);
    assign win_cyc = rx_ctrl_pkg::win_cycles_of(ctrl_reg.window_code, eff_bw);
    // Each good bit is one good high period plus one good low period
    assign pulse_target = rx_ctrl_pkg::pulse_target_of(ctrl_reg.check_code);
    assign status_word = {23'h000000, 2'(state_reg), bad_reg, good_reg};

    always_comb begin
        state_next = state_reg;
        seen_next = seen_reg;
        good_next = good_reg;
        bad_next = bad_reg;
        good_pulse = 1'b0;
        bad_pulse = 1'b0;
        ival_next = (ival_reg == 16'hffff) ? ival_reg : ival_reg + 16'h0001;
        ms_next = ms_reg;
        if (ms_tick && ms_reg != 11'h7ff) begin
            ms_next = ms_reg + 11'h001;
        end
        case (state_reg)
            awake_s: begin
                if (poll_rise) begin
                    state_next = sleep_s;
                    ms_next = 11'h000;
                end
            end
            sleep_s: begin
                if (ms_reg >= sleep_ms) begin
                    ms_next = 11'h000;
                    ival_next = 16'h0000;
                    if (ctrl_reg.check_code == 2'h0) begin
                        state_next = wake_s;
                    end else begin
                        state_next = check_s;
                        seen_next = 1'b0;
                        good_next = 5'h00;
                        bad_next = 2'h0;
                    end
                end
            end
            check_s: begin
                if (edge_seen) begin
                    ival_next = 16'h0000;
                    ms_next = 11'h000;
                    seen_next = 1'b1;
                    // First edge only starts the interval timer
                    if (seen_reg) begin
                        bad_pulse = ival_reg < win_cyc;
                        good_pulse = !bad_pulse;
                    end
                end
                good_next = good_reg + {4'h0, good_pulse};
                bad_next = bad_reg + {1'b0, bad_pulse};
                if (bad_pulse && bad_reg == 2'h1) begin
                    state_next = sleep_s;
                    ms_next = 11'h000;
                end else if (good_pulse && good_next == pulse_target) begin
                    state_next = wake_s;
                end else if (!ctrl_reg.watchdog_disable_bit && ms_reg >= wd_ms) begin
                    state_next = sleep_s;
                    ms_next = 11'h000;
                end
            end
            default: begin
                state_next = state_reg;
            end
        endcase
        if (!ctrl_reg.autopoll_enable_bit) begin
            state_next = awake_s;
        end
        // Gated output stays low while asleep or still checking
        data_out_next = (state_reg == awake_s || state_reg == wake_s) ? data_s : 1'b0;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= awake_s;
            poll_d_reg <= 1'b0;
            data_d_reg <= 1'b0;
            seen_reg <= 1'b0;
            ival_reg <= 16'h0000;
            ms_reg <= 11'h000;
            good_reg <= 5'h00;
            bad_reg <= 2'h0;
            data_out <= 1'b0;
            rx_awake <= 1'b1;
        end else begin
            state_reg <= state_next;
            poll_d_reg <= ctrl_reg.autopoll_enable_bit;
            data_d_reg <= data_s;
            seen_reg <= seen_next;
            ival_reg <= ival_next;
            ms_reg <= ms_next;
            good_reg <= good_next;
            bad_reg <= bad_next;
            data_out <= data_out_next;
            rx_awake <= state_next != sleep_s;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_poll_rise;
        !ctrl_reg.autopoll_enable_bit ##1 ctrl_reg.autopoll_enable_bit;
    endsequence

    sequence s_second_bad;
        state_reg == check_s && bad_reg == 2'h1 ##0 bad_pulse;
    endsequence

    property p_word_load;
        wr_strobe && addr == rx_ctrl_pkg::CTRL_ADDR |=>
            ctrl_reg == $past(wdata[rx_ctrl_pkg::CTRL_W-1:0]);
    endproperty
    a_word_load: assert property (p_word_load) else $error("control word not loaded");

    property p_bw_out;
        // First edge after release still shows the reset value
        !$past(reset) |-> filter_bw_hz == rx_ctrl_pkg::bw_hz_of($past(eff_bw));
    endproperty
    a_bw_out: assert property (p_bw_out) else $error("filter bandwidth mismatch");

    property p_poll_off;
        !ctrl_reg.autopoll_enable_bit |=> state_reg == awake_s;
    endproperty
    a_poll_off: assert property (p_poll_off) else $error("not awake with polling off");

    property p_poll_sleeps;
        (s_poll_rise ##0 state_reg == awake_s) |=> state_reg == sleep_s && !rx_awake;
    endproperty
    a_poll_sleeps: assert property (p_poll_sleeps) else $error("poll enable did not sleep");

    property p_wake_holds;
        state_reg == wake_s && ctrl_reg.autopoll_enable_bit |=> state_reg == wake_s;
    endproperty
    a_wake_holds: assert property (p_wake_holds) else $error("woken state left");

    property p_bad_sleep;
        s_second_bad ##0 ctrl_reg.autopoll_enable_bit |=> state_reg == sleep_s && ms_reg == 0;
    endproperty
    a_bad_sleep: assert property (p_bad_sleep) else $error("bad bit did not sleep");

    property p_gate;
        state_reg == check_s |=> !data_out;
    endproperty
    a_gate: assert property (p_gate) else $error("data leaked during bitcheck");

    property p_watchdog;
        state_reg == check_s && !edge_seen && ctrl_reg.autopoll_enable_bit &&
            !ctrl_reg.watchdog_disable_bit && ms_reg >= wd_ms |=> state_reg == sleep_s;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog did not sleep");

    property p_wd_off;
        state_reg == check_s && !edge_seen && ctrl_reg.autopoll_enable_bit &&
            ctrl_reg.watchdog_disable_bit |=> state_reg == check_s;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("disabled watchdog slept");

    property p_sleep_end;
        state_reg == sleep_s && ms_reg < sleep_ms && ctrl_reg.autopoll_enable_bit
            |=> state_reg == sleep_s;
    endproperty
    a_sleep_end: assert property (p_sleep_end) else $error("sleep ended early");

    property p_rssi;
        ctrl_reg.rssi_offset_bit |=> rssi_offset_mv == rx_ctrl_pkg::RSSI_OFFSET_MV;
    endproperty
    a_rssi: assert property (p_rssi) else $error("strength offset missing");

endmodule : receiver_autopoll_bitcheck_control

//--- hdl/rx_ctrl_pkg.sv
// Constants, control word layout and field decoders for the receiver control block.
// Assumes a 100 MHz system clock and a 1 ms tick standing in for the sleep oscillator.

package rx_ctrl_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int MS_CYCLES_DEF = 1000 * CLK_MHZ;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int CTRL_W = 20;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 20'h00e78;

    typedef struct packed {
        logic rssi_offset_bit;
        logic watchdog_disable_bit;
        logic squelch_bit;
        logic fast_bw_bit;
        logic autopoll_enable_bit;
        logic [2:0] sleep_code;
        logic [2:0] window_code;
        logic [1:0] check_code;
        logic [1:0] slice_code;
        logic [1:0] bw_code;
        logic [2:0] desense_code;
    } ctrl_word_t;

    // ---------------------------------------------------------------
    // Field values
    // ---------------------------------------------------------------
    localparam logic [13:0] BW_BASE_HZ = 14'h0659;
    localparam logic [10:0] SLEEP_BASE_MS = 11'h00a;
    localparam logic [10:0] WD_FAST_MS = 11'h005;
    localparam logic [10:0] WD_MID_MS = 11'h00a;
    localparam logic [10:0] WD_SLOW_MS = 11'h014;
    localparam logic [4:0] PULSE_BASE = 5'h02;
    localparam logic [7:0] RSSI_OFFSET_MV = 8'hc8;
    localparam logic [6:0] SLICE_PCT [4] = '{7'h3c, 7'h1e, 7'h28, 7'h32};

    // Rows by window code, columns from widest to narrowest bandwidth
    localparam logic [9:0] WIN_US [8][4] = '{
        '{10'h043, 10'h088, 10'h10e, 10'h21d},
        '{10'h040, 10'h07e, 10'h0fc, 10'h1f9},
        '{10'h03b, 10'h076, 10'h0ea, 10'h1d5},
        '{10'h036, 10'h06c, 10'h0d8, 10'h1b2},
        '{10'h031, 10'h064, 10'h0c6, 10'h18d},
        '{10'h02d, 10'h05a, 10'h0b4, 10'h169},
        '{10'h029, 10'h052, 10'h0a3, 10'h145},
        '{10'h024, 10'h048, 10'h090, 10'h121}
    };

    function automatic logic [13:0] bw_hz_of(input logic [1:0] c);
        return 14'(BW_BASE_HZ << c);
    endfunction : bw_hz_of

    function automatic logic [10:0] sleep_ms_of(input logic [2:0] c);
        return 11'(SLEEP_BASE_MS << c);
    endfunction : sleep_ms_of

    function automatic logic [10:0] wd_ms_of(input logic [1:0] bw);
        if (bw[1]) begin
            return WD_FAST_MS;
        end else if (bw[0]) begin
            return WD_MID_MS;
        end
        return WD_SLOW_MS;
    endfunction : wd_ms_of

    // Narrow bandwidth codes sit in the long-window columns
    function automatic logic [15:0] win_cycles_of(input logic [2:0] c, input logic [1:0] bw);
        return 16'(int'(WIN_US[c][2'h3 - bw]) * CLK_MHZ);
    endfunction : win_cycles_of

    function automatic logic [4:0] pulse_target_of(input logic [1:0] c);
        return 5'(PULSE_BASE << c);
    endfunction : pulse_target_of

endpackage : rx_ctrl_pkg

//--- hdl/bit_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes each bit is independent; no bus coherence across bits.
`timescale 1ns/1ns
module bit_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // ---------------------------------------------------------------
    // Per-bit stages
    // ---------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_reg;
            logic hold_reg;
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    meta_reg <= 1'b0;
                    hold_reg <= 1'b0;
                end else begin
                    meta_reg <= async_in[i];
                    hold_reg <= meta_reg;
                end
            end
            assign sync_out[i] = hold_reg;
        end
    endgenerate
endmodule : bit_sync

//--- hdl/pulse_divider.sv
// Free-running divider giving a one-cycle enable every DIV clocks.
// Assumes DIV of at least 2.
`timescale 1ns/1ns
module pulse_divider #(
    parameter int DIV = 100000
) (
    input wire logic sys_clk,
    input wire logic reset,
    output logic tick
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_next;

    always_comb begin
        tick_next = (cnt_reg == 32'(DIV - 1));
        cnt_next = tick_next ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule : pulse_divider

//--- verification/data_source.sv
// Far-side model: the demodulated data stream that feeds the control block.
// Assumes sys_clk is the block's clock; each level change lands on a rising edge.
`timescale 1ns/1ns
module data_source (
    input wire logic sys_clk,
    output logic rx_data
);
    initial begin
        rx_data = 1'b0;
    end

    // ------------------------------------------------------------
    // Level-toggle edges
    // ------------------------------------------------------------
    // Alternating levels, so high and low periods each form one pulse
    task automatic toggle(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rx_data <= ~rx_data;
            repeat (gap - 1) @(posedge sys_clk);
        end
    endtask : toggle
endmodule : data_source

//--- verification/testbench.sv
// Self-checking bench for the receiver control block.
// Assumes a 1 ms tick shortened to MS cycles and a data source on rx_data_in.
`timescale 1ns/1ns
module testbench;
    // Short tick keeps sleep and watchdog periods within the run
    localparam int MS = 1000;
    // Above the 36 us window, below the 5 ms watchdog even with one extra tick
    localparam int GOOD = 3800;
    localparam int SHORT = 1000;
    localparam logic [6:0] SLC [4] = '{7'h3c, 7'h1e, 7'h28, 7'h32};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [rx_ctrl_pkg::ADDR_W-1:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic pin_lo = 1'b1;
    logic pin_hi = 1'b1;
    logic [31:0] rdata;
    logic rx_data;
    logic data_out;
    logic rx_awake;
    logic fast_bw;
    logic squelch_en;
    logic [13:0] filter_bw_hz;
    logic [6:0] slice_percent;
    logic [2:0] desense_code;
    logic [7:0] rssi_offset_mv;
    rx_ctrl_pkg::ctrl_word_t cw;
    int bad_count = 0;
    int check_count = 0;
    int n;

    always #5 sys_clk = ~sys_clk;

    receiver_autopoll_bitcheck_control #(.MS_CYCLES(MS)) u_receiver_autopoll_bitcheck_control (
        .sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .bw_select_pin_lo(pin_lo), .bw_select_pin_hi(pin_hi), .rx_data_in(rx_data),
        .data_out(data_out), .rx_awake(rx_awake), .filter_bw_hz(filter_bw_hz),
        .fast_bw(fast_bw), .slice_percent(slice_percent), .desense_code(desense_code),
        .squelch_en(squelch_en), .rssi_offset_mv(rssi_offset_mv)
    );

    data_source u_data_source (.sys_clk(sys_clk), .rx_data(rx_data));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_write(input logic [3:0] a, input logic [19:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= {12'h0, d};
        wr_strobe <= 1'b1;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_read

    task automatic state_is(input logic [1:0] exp);
        logic [31:0] d;
        bus_read(rx_ctrl_pkg::STATUS_ADDR, d);
        check({30'h0, d[8:7]}, {30'h0, exp});
    endtask : state_is

    // Bounded wait on rx_awake; cyc returns the cycles spent
    task automatic wait_awake(input logic val, input int bound, output int cyc);
        cyc = 0;
        while (rx_awake !== val) begin
            @(posedge sys_clk);
            #1;
            cyc++;
            if (cyc > bound) begin
                bad_count++;
                $display("wrong value at %0t: rx_awake wait ran out", $time);
                conclude();
            end
        end
    endtask : wait_awake

    task automatic in_range(input int v, input int lo, input int hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask : in_range

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        repeat (3) @(posedge sys_clk);
        #1;
        check({31'h0, rx_awake}, 32'h1);
        check(32'(filter_bw_hz), 32'd13000);
        check(32'(slice_percent), 32'd50);
        check(32'(desense_code), 32'h0);
        check({31'h0, squelch_en}, 32'h0);
        check({31'h0, fast_bw}, 32'h0);
        check(32'(rssi_offset_mv), 32'h0);
        state_is(2'h0);
        bus_read(rx_ctrl_pkg::CTRL_ADDR, d);
        check(d, 32'h0);
        cw = rx_ctrl_pkg::CTRL_RESET;
        cw.autopoll_enable_bit = 1'b1;
        bus_write(4'h8, cw);
        repeat (4) @(posedge sys_clk);
        #1;
        check({31'h0, rx_awake}, 32'h1);
    endtask : t_reset

    task automatic t_decode;
        for (int c = 0; c < 4; c++) begin
            cw = rx_ctrl_pkg::CTRL_RESET;
            cw.bw_code = 2'(c);
            cw.slice_code = 2'(c);
            cw.fast_bw_bit = c[0];
            cw.rssi_offset_bit = c[1];
            bus_write(rx_ctrl_pkg::CTRL_ADDR, cw);
            repeat (2) @(posedge sys_clk);
            #1;
            check(32'(filter_bw_hz), 32'h659 << c);
            check(32'(slice_percent), 32'(SLC[c]));
            check({31'h0, fast_bw}, 32'(c[0]));
            check(32'(rssi_offset_mv), c[1] ? 32'd200 : 32'h0);
        end
        @(posedge sys_clk);
        pin_lo <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        check(32'(filter_bw_hz), 32'd6500);
        pin_lo <= 1'b1;
        bus_write(rx_ctrl_pkg::CTRL_ADDR, rx_ctrl_pkg::CTRL_RESET);
    endtask : t_decode

    task automatic t_poll_plain;
        cw = rx_ctrl_pkg::CTRL_RESET;
        cw.autopoll_enable_bit = 1'b1;
        bus_write(rx_ctrl_pkg::CTRL_ADDR, cw);
        wait_awake(1'b0, 5, n);
        check({31'h0, data_out}, 32'h0);
        wait_awake(1'b1, 11 * MS, n);
        in_range(n, 9 * MS - 2, 10 * MS + 5);
        state_is(2'h3);
        u_data_source.toggle(1, 8);
        check({31'h0, data_out}, {31'h0, rx_data});
        repeat (2 * MS) @(posedge sys_clk);
        #1;
        check({31'h0, rx_awake}, 32'h1);
        bus_write(rx_ctrl_pkg::CTRL_ADDR, rx_ctrl_pkg::CTRL_RESET);
        state_is(2'h0);
    endtask : t_poll_plain

    task automatic t_bitcheck;
        cw = rx_ctrl_pkg::CTRL_RESET;
        cw.check_code = 2'h1;
        cw.autopoll_enable_bit = 1'b1;
        bus_write(rx_ctrl_pkg::CTRL_ADDR, cw);
        wait_awake(1'b0, 5, n);
        wait_awake(1'b1, 11 * MS, n);
        state_is(2'h2);
        // Pulses shorter than the window count as bad
        u_data_source.toggle(3, SHORT);
        check({31'h0, rx_awake}, 32'h0);
        state_is(2'h1);
        wait_awake(1'b1, 11 * MS, n);
        // Sleep began one short gap before this wait started
        in_range(n, 9 * MS - SHORT - 2, 10 * MS - SHORT + 5);
        u_data_source.toggle(4, GOOD);
        state_is(2'h2);
        check({31'h0, data_out}, 32'h0);
        u_data_source.toggle(1, 8);
        state_is(2'h3);
        check({31'h0, data_out}, {31'h0, rx_data});
    endtask : t_bitcheck

    task automatic t_watchdog;
        cw.autopoll_enable_bit = 1'b0;
        bus_write(rx_ctrl_pkg::CTRL_ADDR, cw);
        cw.autopoll_enable_bit = 1'b1;
        bus_write(rx_ctrl_pkg::CTRL_ADDR, cw);
        wait_awake(1'b0, 5, n);
        wait_awake(1'b1, 11 * MS, n);
        wait_awake(1'b0, 6 * MS, n);
        in_range(n, 4 * MS - 2, 5 * MS + 5);
        cw.watchdog_disable_bit = 1'b1;
        bus_write(rx_ctrl_pkg::CTRL_ADDR, cw);
        wait_awake(1'b1, 11 * MS, n);
        repeat (6 * MS) @(posedge sys_clk);
        #1;
        check({31'h0, rx_awake}, 32'h1);
        state_is(2'h2);
        bus_write(rx_ctrl_pkg::CTRL_ADDR, rx_ctrl_pkg::CTRL_RESET);
    endtask : t_watchdog

    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_decode();
        t_poll_plain();
        t_bitcheck();
        t_watchdog();
        conclude();
    end
endmodule : testbench
